// ---- design/ewc_consts.svh ----
`ifndef EWC_CONSTS_SVH
`define EWC_CONSTS_SVH

// ------------------------------------------------------------------
// Image layout (byte addresses in the configuration memory)
// ------------------------------------------------------------------
`define EWC_IMG_WAKE_FLAGS0 10'h009
`define EWC_IMG_WAKE_FLAGS1 10'h00A
`define EWC_IMG_PTR_FIRST   10'h02F
`define EWC_PTR_LAST_IDX    5'h18
`define EWC_PTR_PAIRS       10
`define EWC_PTR_WUF_LEN     5'h0E
`define EWC_PTR_WUF_OFF     5'h0F
`define EWC_PTR_SW_LEN      5'h17
`define EWC_WUF_LEN_BYTES   8'h14
`define EWC_WUF_LAST_IDX    5'h13

// ------------------------------------------------------------------
// Wake flag bit positions
// ------------------------------------------------------------------
`define EWC_F0_MASTER_EN 7
`define EWC_F0_PULSE     6
`define EWC_F0_LONG      5
`define EWC_F0_POL_HIGH  4
`define EWC_F0_PUSH_PULL 3
`define EWC_F0_PKT_EN    1
`define EWC_F0_DA_EN     0
`define EWC_F1_WAKE_FRAME_FILTER_MATCH_EN   0

// ------------------------------------------------------------------
// Register word indexes (byte address = index * 4)
// ------------------------------------------------------------------
`define EWC_W_CTRL   6'h00
`define EWC_W_STATUS 6'h01
`define EWC_W_FLAGS  6'h02
`define EWC_W_FCFG   6'h03
`define EWC_W_MASK0  6'h04
`define EWC_W_MASK3  6'h07
`define EWC_W_PAIR0  6'h08
`define EWC_W_PAIRL  6'h12
`define EWC_W_RAW0   6'h20
`define EWC_W_RAWL   6'h38
`define EWC_CTRL_START 0
`define EWC_CTRL_CLEAR 1

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define EWC_CLK_HZ         20000000
`define EWC_PULSE_SHORT_US 1500
`define EWC_PULSE_LONG_US  150000

`endif

// ---- design/ewc_pkg.sv ----
package ewc_pkg;

   typedef enum logic [2:0] {
      EWC_IDLE  = 3'b000,
      EWC_FLAG0 = 3'b001,
      EWC_FLAG1 = 3'b010,
      EWC_PTR   = 3'b011,
      EWC_FILT  = 3'b100
   } ewc_state_e;

   typedef struct packed {
      logic master_en;
      logic pulse_mode;
      logic long_sel;
      logic pol_high;
      logic push_pull;
   } ewc_wake_cfg_s;

endpackage

// ---- design/ewc_sync3.sv ----
`timescale 1ns/1ns
module ewc_sync3 (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic f1_q;
   logic f2_q;
   logic f3_q;

   // Level only moves once the two settled stages agree
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         f1_q <= 1'b0;
         f2_q <= 1'b0;
         f3_q <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         f1_q <= d_i;
         f2_q <= f1_q;
         f3_q <= f2_q;
         if (f2_q == f3_q) begin
            q_o <= f3_q;
         end
      end
   end
endmodule // ewc_sync3

// ---- design/ewc_wake_pin.sv ----
`timescale 1ns/1ns
module ewc_wake_pin #(
   parameter logic [21:0] SHORT_CYC = 22'h00_7530,
   parameter logic [21:0] LONG_CYC  = 22'h2D_C6C0
) (
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire ewc_pkg::ewc_wake_cfg_s cfg_i,
   input  wire logic                  evt_i,
   input  wire logic                  clear_i,
   output logic                       pin_o,
   output logic                       pin_oe_n_o,
   output logic                       pending_o
);
   logic [21:0] cnt_q;
   logic        pulse_q;
   wire  [21:0] lim      = cfg_i.long_sel ? LONG_CYC : SHORT_CYC;
   wire         last     = cnt_q == lim - 22'h00_0001;
   wire         start    = cfg_i.master_en & cfg_i.pulse_mode & evt_i & ~pulse_q;
   wire         act      = cfg_i.pulse_mode ? pulse_q : pending_o;
   wire         level    = act ? cfg_i.pol_high : ~cfg_i.pol_high;
   wire         out_d    = cfg_i.master_en & cfg_i.push_pull & level;
   wire         oe_n_d   = ~cfg_i.master_en | (~cfg_i.push_pull & level);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pending_o <= 1'b0;
      end else begin
         pending_o <= evt_i | (pending_o & ~clear_i);
      end
   end

   // Events during a pulse are dropped, never restart the count
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pulse_q <= 1'b0;
         cnt_q   <= 22'h00_0000;
      end else if (start) begin
         pulse_q <= 1'b1;
         cnt_q   <= 22'h00_0000;
      end else if (pulse_q) begin
         pulse_q <= ~last;
         cnt_q   <= cnt_q + 22'h00_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_o      <= 1'b0;
         pin_oe_n_o <= 1'b1;
      end else begin
         pin_o      <= out_d;
         pin_oe_n_o <= oe_n_d;
      end
   end

   a_master_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !cfg_i.master_en |=> pin_oe_n_o && !pin_o)
      else $error("wake pin driven while disabled");
   a_pulse_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pulse_q && cnt_q == lim - 22'h00_0001 |=> !pulse_q)
      else $error("pulse did not end at its length");
   a_no_retrigger: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pulse_q && !last |=> pulse_q && cnt_q == $past(cnt_q) + 22'h00_0001)
      else $error("pulse count disturbed");
   a_pushpull_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cfg_i.master_en && cfg_i.push_pull |=> !pin_oe_n_o)
      else $error("push-pull pin not driven");
   a_polarity_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cfg_i.master_en && cfg_i.push_pull && act |=> pin_o == $past(cfg_i.pol_high))
      else $error("wrong active level");
   a_level_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      pending_o && !clear_i |=> pending_o)
      else $error("wake level dropped early");
   a_pulse_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start |=> pulse_q ##1 (pin_o == cfg_i.pol_high || !cfg_i.push_pull))
      else $error("pulse did not start");
endmodule // ewc_wake_pin

// ---- design/ewc_loader.sv ----
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "ewc_consts.svh"
// How it works
// - Read length and offset pairs per descriptor
// - High-speed config block at 37h and 38h
// - Full-speed descriptors via 39h to 3Ch
// - Filter 0: 4 config, 16 mask bytes
// - Software descriptor pair at 46h and 47h
// - Master enable lets wake events drive pin
// - Master clear: no wake, other bits ignored
// - Bit 6 selects level or pulse
// - Bit 5 selects 1.5 ms or 150 ms
// - Pulse timed from first event, no restart
// - Bit 4 sets active polarity
// - Bit 3 selects open-drain or push-pull
// - Packet and address wake enables, gated
// - Frame enable loads filter 0 from image if its length is 14h
module ewc_loader #(
   parameter logic [21:0] PULSE_SHORT_CYC =
      22'(64'(`EWC_PULSE_SHORT_US) * 64'(`EWC_CLK_HZ) / 64'd1000000),
   parameter logic [21:0] PULSE_LONG_CYC =
      22'(64'(`EWC_PULSE_LONG_US) * 64'(`EWC_CLK_HZ) / 64'd1000000)
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             mem_req_o,
   output logic      [9:0]  mem_addr_o,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic        mem_ack_i,
   input  wire logic        wake_pin_evt_i,
   input  wire logic        packet_match_i,
   input  wire logic        wake_frame_filter_match_i,
   input  wire logic        exact_dest_addr_match_i,
   output logic             wake_out_pin_o,
   output logic             wake_out_pin_oe_n_o,
   output logic             load_done_o
);

   // ------------------------------------------------------------------
   // Loader state
   // ------------------------------------------------------------------
   ewc_pkg::ewc_state_e state_q;
   ewc_pkg::ewc_state_e state_d;
   logic [4:0]          idx_q;
   logic [4:0]          idx_d;
   logic                req_d;
   logic [9:0]          addr_d;
   logic [7:0]          flags0_q;
   logic [7:0]          flags1_q;
   logic [7:0]          ptr_q [25];
   logic [7:0]          filt_q [20];
   logic                start_pend_q;
   logic                filt_loaded_q;
   logic                pin_lvl;
   logic                pin_lvl_q;
   logic                wake_pending;

   wire idle      = state_q == ewc_pkg::EWC_IDLE;
   wire start_go  = idle & start_pend_q;
   wire ptr_ack   = state_q == ewc_pkg::EWC_PTR & mem_ack_i;
   wire filt_ack  = state_q == ewc_pkg::EWC_FILT & mem_ack_i;
   wire ptr_last  = idx_q == `EWC_PTR_LAST_IDX;
   wire filt_last = idx_q == `EWC_WUF_LAST_IDX;
   // Filter only loaded from a well-formed block
   wire wake_frame_filter_match_go   = flags1_q[`EWC_F1_WAKE_FRAME_FILTER_MATCH_EN]
                  & (ptr_q[`EWC_PTR_WUF_LEN] == `EWC_WUF_LEN_BYTES);
   wire [9:0] filt_base = {1'b0, ptr_q[`EWC_PTR_WUF_OFF], 1'b0};
   wire finish    = (ptr_ack & ptr_last & ~wake_frame_filter_match_go) | (filt_ack & filt_last);

   // ------------------------------------------------------------------
   // Image walk: wake flags, pointer table, then optional filter 0
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      req_d   = mem_req_o;
      addr_d  = mem_addr_o;
      unique case (state_q)
         ewc_pkg::EWC_IDLE: begin
            if (start_go) begin
               state_d = ewc_pkg::EWC_FLAG0;
               req_d   = 1'b1;
               addr_d  = `EWC_IMG_WAKE_FLAGS0;
            end
         end
         ewc_pkg::EWC_FLAG0: begin
            if (mem_ack_i) begin
               state_d = ewc_pkg::EWC_FLAG1;
               addr_d  = `EWC_IMG_WAKE_FLAGS1;
            end
         end
         ewc_pkg::EWC_FLAG1: begin
            if (mem_ack_i) begin
               state_d = ewc_pkg::EWC_PTR;
               idx_d   = 5'h00;
               addr_d  = `EWC_IMG_PTR_FIRST;
            end
         end
         ewc_pkg::EWC_PTR: begin
            if (mem_ack_i && ptr_last && wake_frame_filter_match_go) begin
               state_d = ewc_pkg::EWC_FILT;
               idx_d   = 5'h00;
               addr_d  = filt_base;
            end else if (mem_ack_i && ptr_last) begin
               state_d = ewc_pkg::EWC_IDLE;
               req_d   = 1'b0;
            end else if (mem_ack_i) begin
               idx_d   = idx_q + 5'h01;
               addr_d  = `EWC_IMG_PTR_FIRST + 10'(idx_d);
            end
         end
         ewc_pkg::EWC_FILT: begin
            if (mem_ack_i && filt_last) begin
               state_d = ewc_pkg::EWC_IDLE;
               req_d   = 1'b0;
            end else if (mem_ack_i) begin
               idx_d   = idx_q + 5'h01;
               addr_d  = mem_addr_o + 10'h001;
            end
         end
         default: begin
            state_d = ewc_pkg::EWC_IDLE;
            req_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_q    <= ewc_pkg::EWC_IDLE;
         idx_q      <= 5'h00;
         mem_req_o  <= 1'b0;
         mem_addr_o <= 10'h000;
      end else begin
         state_q    <= state_d;
         idx_q      <= idx_d;
         mem_req_o  <= req_d;
         mem_addr_o <= addr_d;
      end
   end

   // ------------------------------------------------------------------
   // Captured image bytes
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         flags0_q <= 8'h00;
         flags1_q <= 8'h00;
      end else if (state_q == ewc_pkg::EWC_FLAG0 && mem_ack_i) begin
         flags0_q <= mem_rdata_i;
      end else if (state_q == ewc_pkg::EWC_FLAG1 && mem_ack_i) begin
         flags1_q <= mem_rdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < 25; i++) begin
            ptr_q[i] <= 8'h00;
         end
      end else if (ptr_ack) begin
         ptr_q[idx_q] <= mem_rdata_i;
      end
   end

   // Bytes 0..3 config, 4..19 mask, kept in image order
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < 20; i++) begin
            filt_q[i] <= 8'h00;
         end
      end else if (filt_ack) begin
         filt_q[idx_q] <= mem_rdata_i;
      end
   end

   // ------------------------------------------------------------------
   // APB slave, one wait state, answer from flops
   // ------------------------------------------------------------------
   wire       apb_acc   = psel_i & penable_i;
   wire       apb_fire  = apb_acc & pready_o;
   wire       wr_fire   = apb_fire & pwrite_i;
   wire [5:0] word_a    = paddr_i[7:2];
   wire       aligned   = paddr_i[1:0] == 2'b00;
   wire       hit_ctrl  = aligned & (word_a == `EWC_W_CTRL);
   wire       hit_stat  = aligned & (word_a == `EWC_W_STATUS);
   wire       hit_flag  = aligned & (word_a == `EWC_W_FLAGS);
   wire       hit_fcfg  = aligned & (word_a == `EWC_W_FCFG);
   wire       hit_mask  = aligned & (word_a >= `EWC_W_MASK0) & (word_a <= `EWC_W_MASK3);
   wire       hit_pair  = aligned & (word_a >= `EWC_W_PAIR0) & (word_a <= `EWC_W_PAIRL);
   wire       hit_raw   = aligned & (word_a >= `EWC_W_RAW0) & (word_a <= `EWC_W_RAWL);
   wire       hit_any   = hit_ctrl | hit_stat | hit_flag | hit_fcfg | hit_mask
                        | hit_pair | hit_raw;
   wire [3:0] pair_idx  = 4'(word_a - `EWC_W_PAIR0);
   wire [4:0] raw_idx   = 5'(word_a - `EWC_W_RAW0);
   wire [1:0] mask_idx  = word_a[1:0];
   wire       ctrl_start = wr_fire & hit_ctrl & pwdata_i[`EWC_CTRL_START];
   wire       ctrl_clear = wr_fire & hit_ctrl & pwdata_i[`EWC_CTRL_CLEAR];

   logic [31:0] pair_word [11];
   logic [31:0] mask_word [4];

   // Length in low byte, word offset above it
   for (genvar p = 0; p < 11; p++) begin : g_pair
      localparam int B = (p < `EWC_PTR_PAIRS) ? 2 * p : int'(`EWC_PTR_SW_LEN);
      assign pair_word[p] = {16'h0000, ptr_q[B + 1], ptr_q[B]};
   end

   for (genvar m = 0; m < 4; m++) begin : g_mask
      assign mask_word[m] = {filt_q[4 * m + 7], filt_q[4 * m + 6],
                             filt_q[4 * m + 5], filt_q[4 * m + 4]};
   end

   wire [31:0] fcfg_word = {filt_q[3], filt_q[2], filt_q[1], filt_q[0]};
   wire [31:0] stat_word = {27'h000_0000, pin_lvl_q, wake_pending,
                            filt_loaded_q, load_done_o, ~idle};
   wire [31:0] rd_word   = hit_stat ? stat_word :
                           hit_flag ? {16'h0000, flags1_q, flags0_q} :
                           hit_fcfg ? fcfg_word :
                           hit_mask ? mask_word[mask_idx] :
                           hit_pair ? pair_word[pair_idx] :
                           hit_raw  ? {24'h00_0000, ptr_q[raw_idx]} :
                                      32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= apb_acc & ~pready_o;
         prdata_o  <= (apb_acc & ~pwrite_i) ? rd_word : 32'h0000_0000;
         pslverr_o <= apb_acc & ~pready_o & ~hit_any;
      end
   end

   // A start request is kept while a load runs, so none is lost
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         start_pend_q  <= 1'b1;
         load_done_o   <= 1'b0;
         filt_loaded_q <= 1'b0;
      end else begin
         start_pend_q  <= ctrl_start | (start_pend_q & ~start_go);
         load_done_o   <= finish | (load_done_o & ~start_go);
         filt_loaded_q <= (filt_ack & filt_last) | (filt_loaded_q & ~start_go);
      end
   end

   // ------------------------------------------------------------------
   // Wake event gating
   // ------------------------------------------------------------------
   ewc_pkg::ewc_wake_cfg_s wake_cfg;
   assign wake_cfg.master_en  = flags0_q[`EWC_F0_MASTER_EN];
   assign wake_cfg.pulse_mode = flags0_q[`EWC_F0_PULSE];
   assign wake_cfg.long_sel   = flags0_q[`EWC_F0_LONG];
   assign wake_cfg.pol_high   = flags0_q[`EWC_F0_POL_HIGH];
   assign wake_cfg.push_pull  = flags0_q[`EWC_F0_PUSH_PULL];

   ewc_sync3 u_pin_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .d_i      (wake_pin_evt_i),
      .q_o      (pin_lvl)
   );

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pin_lvl_q <= 1'b0;
      end else begin
         pin_lvl_q <= pin_lvl;
      end
   end

   wire pin_rise = pin_lvl & ~pin_lvl_q;
   wire wake_frame_filter_match_en  = flags1_q[`EWC_F1_WAKE_FRAME_FILTER_MATCH_EN] & filt_loaded_q;
   wire wake_evt = wake_cfg.master_en
                 & (pin_rise
                 | (packet_match_i & flags0_q[`EWC_F0_PKT_EN])
                 | (exact_dest_addr_match_i & flags0_q[`EWC_F0_DA_EN])
                 | (wake_frame_filter_match_i & wake_frame_filter_match_en));

   ewc_wake_pin #(
      .SHORT_CYC (PULSE_SHORT_CYC),
      .LONG_CYC  (PULSE_LONG_CYC)
   ) u_wake_pin (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .cfg_i      (wake_cfg),
      .evt_i      (wake_evt),
      .clear_i    (ctrl_clear),
      .pin_o      (wake_out_pin_o),
      .pin_oe_n_o (wake_out_pin_oe_n_o),
      .pending_o  (wake_pending)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_ptr_capture: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ptr_ack |=> ptr_q[$past(idx_q)] == $past(mem_rdata_i))
      else $error("pointer byte not captured");
   a_filter_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ptr_ack && ptr_last |=> (state_q == ewc_pkg::EWC_FILT) == $past(wake_frame_filter_match_go))
      else $error("filter load decision wrong");
   a_filter_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
      filt_ack && idx_q == 5'h03 |=> fcfg_word[31:24] == $past(mem_rdata_i))
      else $error("filter config byte misplaced");
   a_dest_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !flags0_q[`EWC_F0_DA_EN] && !pin_rise && !packet_match_i
      && !wake_frame_filter_match_i |-> !wake_evt)
      else $error("address wake not gated");
   a_wake_trigger: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wake_cfg.master_en && pin_rise |=> wake_pending)
      else $error("wake event did not set pending");
   a_master_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !wake_cfg.master_en |-> !wake_evt)
      else $error("wake event while master enable clear");
   a_packet_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wake_cfg.master_en && flags0_q[`EWC_F0_PKT_EN] && packet_match_i |=> wake_pending)
      else $error("packet wake lost");
   a_sw_pair: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ptr_ack && ptr_last |=> pair_word[10][15:8] == $past(mem_rdata_i))
      else $error("software descriptor offset not captured");
   a_load_finish: assert property (@(posedge clk_i) disable iff (!resetn_i)
      finish |=> load_done_o && !mem_req_o && idle)
      else $error("load did not finish cleanly");
endmodule // ewc_loader

// ---- sim/ewc_mem_model.sv ----
`timescale 1ns/1ns
module ewc_mem_model (
   input  wire logic       clk_i,
   input  wire logic       mem_req_i,
   input  wire logic [9:0] mem_addr_i,
   output logic      [7:0] mem_rdata_o,
   output logic            mem_ack_o
);
   // ------------------------------------------------------------
   // Image and byte port
   // ------------------------------------------------------------
   logic [7:0] img [1024];
   int         wait_q = 0;

   initial begin
      mem_rdata_o = 8'h00;
      mem_ack_o   = 1'b0;
   end

   // Data toggles outside ack so a stale byte is never mistaken for a fresh one
   always @(posedge clk_i) begin
      if (mem_ack_o) begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         wait_q      <= $urandom_range(3);
      end else if (mem_req_i && wait_q == 0) begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= img[mem_addr_i];
      end else begin
         mem_rdata_o <= ~mem_rdata_o;
         if (mem_req_i)
            wait_q <= wait_q - 1;
      end
   end
endmodule // ewc_mem_model

// ---- sim/test_ewc_loader.sv ----
`timescale 1ns/1ns
module test_ewc_loader;
   logic        clk_i     = 1'b0;
   logic        resetn_i  = 1'b0;
   logic        psel_i    = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i  = 1'b0;
   logic [7:0]  paddr_i   = 8'h00;
   logic [31:0] pwdata_i  = 32'h0;
   logic [3:0]  evt       = 4'h0;
   logic [31:0] prdata_o;
   logic        pready_o, pslverr_o, mem_req_o, mem_ack_i;
   logic [9:0]  mem_addr_o;
   logic [7:0]  mem_rdata_i;
   logic        wake_out_pin_o, wake_out_pin_oe_n_o, load_done_o;
   logic [32:0] exp_q [$];
   int          mismatches  = 0;
   int          check_count = 0;
   int          n_act, n_bad;
   logic [7:0]  flg;
   logic [7:0]  cf [6] = '{8'hC2, 8'hF9, 8'hC8, 8'hC8, 8'hC9, 8'h6B};
   int          ck [6] = '{0, 1, 2, 3, 0, 0};
   int          ce [6] = '{10, 40, 10, 10, 0, 0};

   always #25 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // Design and image memory
   // ------------------------------------------------------------
   ewc_loader #(.PULSE_SHORT_CYC(22'h0_000A), .PULSE_LONG_CYC(22'h0_0028)) DUT (
      .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_addr_o, .mem_rdata_i,
      .mem_ack_i, .wake_pin_evt_i(evt[2]), .packet_match_i(evt[0]),
      .wake_frame_filter_match_i(evt[3]), .exact_dest_addr_match_i(evt[1]),
      .wake_out_pin_o, .wake_out_pin_oe_n_o, .load_done_o);

   ewc_mem_model u_mem (.clk_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] b(input int a);
      return u_mem.img[a];
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] expv);
      check_count++;
      if (seen !== expv) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the watchdog ends a wait for ready
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   always @(posedge clk_i) begin
      if (pready_o === 1'b1)
         check({pslverr_o, prdata_o}, exp_q.size() ? exp_q.pop_front() : 33'h1_DEAD_BEEF);
   end

   task automatic wait_load;
      while (mem_req_o !== 1'b1)
         @(posedge clk_i);
      while (mem_req_o !== 1'b0)
         @(posedge clk_i);
      repeat (3) @(posedge clk_i);
   endtask

   // Open drain counts as pulled up when released
   task automatic count(input int n);
      logic lvl;
      n_act = 0;
      n_bad = 0;
      repeat (n) begin
         @(posedge clk_i);
         lvl = wake_out_pin_oe_n_o ? 1'b1 : wake_out_pin_o;
         if (lvl === flg[4])
            n_act++;
         if (!flg[7] ? (wake_out_pin_oe_n_o !== 1'b1 || wake_out_pin_o !== 1'b0) :
             flg[3] ? wake_out_pin_oe_n_o !== 1'b0 : wake_out_pin_o !== 1'b0)
            n_bad++;
      end
   endtask

   task automatic fire(input int k);
      @(posedge clk_i);
      evt[k] <= 1'b1;
      // Pin filter needs two agreeing samples, so hold the pin longer
      repeat (k == 2 ? 4 : 1) @(posedge clk_i);
      evt[k] <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int p, j;
      void'($urandom(30));
      for (j = 0; j < 1024; j++)
         u_mem.img[j] = 8'($urandom);
      u_mem.img[10'h009] = 8'h9A;
      u_mem.img[10'h00A] = 8'h01;
      u_mem.img[10'h03D] = 8'h14;
      u_mem.img[10'h03E] = 8'h40;
      u_mem.img[10'h03F] = 8'h18;
      u_mem.img[10'h041] = 8'h04;
      u_mem.img[10'h043] = 8'h00;
      u_mem.img[10'h044] = 8'h02;
      u_mem.img[10'h045] = 8'h00;
      for (j = 'h50; j <= 'h61; j++)
         u_mem.img[j] = 8'h00;
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      wait_load;
      check(33'(load_done_o), 33'h1);
      apb(1'b0, 8'h04, 32'h0, 33'h6);
      apb(1'b0, 8'h08, 32'h0, {17'h0, b('h0A), b('h09)});
      for (p = 0; p < 11; p++)
         apb(1'b0, 8'(8'h20 + 4 * p), 32'h0, {17'h0, b(p < 10 ? 'h30 + 2 * p : 'h47),
             b(p < 10 ? 'h2F + 2 * p : 'h46)});
      for (j = 0; j < 5; j++)
         apb(1'b0, 8'(8'h0C + 4 * j), 32'h0, {1'b0, b(131 + 4 * j), b(130 + 4 * j),
             b(129 + 4 * j), b(128 + 4 * j)});
      for (j = 0; j < 25; j++)
         apb(1'b0, 8'(8'h80 + 4 * j), 32'h0, {25'h0, b(47 + j)});
      apb(1'b0, 8'hFC, 32'h0, 33'h1_0000_0000);
      apb(1'b1, 8'h22, 32'hFFFF_FFFF, 33'h1_0000_0000);
      // Level mode holds until software clears pending
      flg = 8'h9A;
      fire(0);
      repeat (6) @(posedge clk_i);
      count(30);
      check(33'(n_act), 33'd30);
      apb(1'b1, 8'h00, 32'h0000_0002, 33'h0);
      repeat (4) @(posedge clk_i);
      count(30);
      check(33'(n_act), 33'd0);
      for (j = 0; j < 6; j++) begin
         flg = cf[j];
         u_mem.img[10'h009] = flg;
         apb(1'b1, 8'h00, 32'h0000_0003, 33'h0);
         wait_load;
         fork
            count(60);
            begin
               fire(ck[j]);
               repeat (5) @(posedge clk_i);
               fire(ck[j]);
            end
         join
         check(33'(n_act), 33'(ce[j]));
         check(33'(n_bad), 33'd0);
      end
      give_verdict;
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      mismatches++;
      give_verdict;
   end
endmodule // test_ewc_loader
